// ===== logic/lcdl_frame_timer.sv
// Frame timer: divides oscillator ticks into frame halves
`timescale 1ns/1ps
`include "lcdl_cfg.svh"
module lcdl_frame_timer
    import lcdl_pkg::*;
#(
    parameter int FRAME_DIV = `LCDL_FRAME_DIV,
    parameter int PW = $clog2(FRAME_DIV / 2)
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic enable,
    input wire logic osc_tick,
    output logic [PW-1:0] pos_q,
    output logic pol_q,
    output logic frame_clk_q
);
    localparam logic [PW-1:0] HALF_LAST = PW'(FRAME_DIV / 2 - 1);

    // Slots of 1, 2 and 3 backplanes must split each half evenly
    if (FRAME_DIV % 12 != 0 || FRAME_DIV < 12) begin : g_chk
        $error("FRAME_DIV must be a positive multiple of 12");
    end

    always_ff @(posedge clk) begin
        if (srst || !enable) begin
            pos_q <= '0;
            pol_q <= 1'b0;
        end else if (osc_tick) begin
            if (pos_q == HALF_LAST) begin
                pos_q <= '0;
                pol_q <= ~pol_q;
            end else begin
                pos_q <= pos_q + PW'(1);
            end
        end
    end

    // Internal frame clock: one pulse per frame half
    always_ff @(posedge clk) begin
        if (srst || !enable) begin
            frame_clk_q <= 1'b0;
        end else begin
            frame_clk_q <= osc_tick && (pos_q == HALF_LAST); // RULE5
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    AST_FRAME_HALF: assert property (frame_clk_q |-> pos_q == '0) // RULE5
        else $error("frame clock pulse not at start of frame half");
    AST_POL_FLIP: assert property (enable && $past(enable) && frame_clk_q
        |-> pol_q != $past(pol_q)) // RULE15
        else $error("polarity did not flip at frame half");
endmodule

// ===== logic/lcdl_latch_drive.sv
// Display latch, backplane sequencer and segment level selection
// How it works
// (RULE1) Hold 96 display bits for the drive
// (RULE2) One bit per segment, one means on
// (RULE3) Latch frozen while shift window enabled
// (RULE4) Copy only on the internal frame clock
// (RULE5) Frame rate is oscillator divided by 2400
// (RULE6) Segment n uses banks per active mode
// (RULE7) 32 segment waveforms from phase and data
// (RULE8) Three backplane waveforms follow drive mode
// (RULE9) Duplex: third backplane at half bias
// (RULE10) Static: second, third backplanes at ground
// (RULE11) Mode pins: test, static, duplex, triplex
// (RULE12) Host holds shift enable high while shifting
// (RULE13) After reset outputs ground until serial clock
// (RULE14) Outputs are level select codes for switches
// (RULE15) Equal slots per backplane, polarity alternates
`timescale 1ns/1ps
`include "lcdl_cfg.svh"
module lcdl_latch_drive
    import lcdl_pkg::*;
#(
    parameter int FRAME_DIV = `LCDL_FRAME_DIV,
    parameter int NUM_SEG = `LCDL_NUM_SEG
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic osc_tick,
    input wire logic serial_clock,
    input wire logic shift_window_enable,
    input wire logic drive_mode_sel_low,
    input wire logic drive_mode_sel_high,
    input wire logic [NUM_SEG*`LCDL_NUM_BANK-1:0] shift_reg_data,
    output logic [2*NUM_SEG-1:0] segment_drive_outputs,
    output logic [1:0] backplane_out_first,
    output logic [1:0] backplane_out_second,
    output logic [1:0] backplane_out_third
);
    localparam int PW = $clog2(FRAME_DIV / 2);
    localparam int DW = NUM_SEG * `LCDL_NUM_BANK;
    localparam logic [PW-1:0] DUP_SPLIT = PW'(FRAME_DIV / 4);
    localparam logic [PW-1:0] TRI_SPLIT1 = PW'(FRAME_DIV / 6);
    localparam logic [PW-1:0] TRI_SPLIT2 = PW'(FRAME_DIV / 3);

    if (NUM_SEG < 1) begin : g_chk
        $error("NUM_SEG must be at least one");
    end

    logic sclk_q;
    logic active_q;
    logic [DW-1:0] latch_q;
    logic [PW-1:0] pos;
    logic pol;
    logic frame_clk;
    lcdl_mode_t mode;
    logic [1:0] slot;
    lcdl_level_t bp_d [`LCDL_NUM_BP];
    logic [2*NUM_SEG-1:0] seg_d;
    logic drive_on;

    assign mode = lcdl_mode_t'({drive_mode_sel_high, drive_mode_sel_low}); // RULE11
    assign drive_on = active_q && (mode != LCDL_MODE_TEST);

    lcdl_frame_timer #(
        .FRAME_DIV(FRAME_DIV),
        .PW(PW)
    ) u_timer (
        .clk(clk),
        .srst(srst),
        .enable(active_q),
        .osc_tick(osc_tick),
        .pos_q(pos),
        .pol_q(pol),
        .frame_clk_q(frame_clk)
    );

    // Powered down until the first rising serial clock edge; the sample runs
    // through reset so a line already high at release is not taken as an edge
    always_ff @(posedge clk) begin
        sclk_q <= serial_clock;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            active_q <= 1'b0;
        end else if (serial_clock && !sclk_q) begin
            active_q <= 1'b1; // RULE13
        end
    end

    // Display latch
    always_ff @(posedge clk) begin
        if (srst) begin
            latch_q <= '0;
        end else if (active_q && frame_clk && !shift_window_enable) begin // RULE3 RULE4
            latch_q <= shift_reg_data; // RULE1
        end
    end

    // Backplane time slot within the current frame half
    always_comb begin
        slot = 2'd0;
        unique case (mode)
            LCDL_MODE_DUPLEX: begin
                slot = (pos >= DUP_SPLIT) ? 2'd1 : 2'd0; // RULE15
            end
            LCDL_MODE_TRIPLEX: begin
                if (pos >= TRI_SPLIT2) begin
                    slot = 2'd2;
                end else if (pos >= TRI_SPLIT1) begin
                    slot = 2'd1;
                end else begin
                    slot = 2'd0;
                end
            end
            LCDL_MODE_STATIC, LCDL_MODE_TEST: begin
                slot = 2'd0;
            end
        endcase
    end

    // Backplane levels: selected plate swings rail to rail
    for (genvar b = 0; b < `LCDL_NUM_BP; b++) begin : g_bp
        always_comb begin
            bp_d[b] = `LCDL_LV_GND;
            unique case (mode)
                LCDL_MODE_STATIC: begin
                    if (b == 0) begin
                        bp_d[b] = pol ? `LCDL_LV_FULL : `LCDL_LV_GND; // RULE8
                    end else begin
                        bp_d[b] = `LCDL_LV_GND; // RULE10
                    end
                end
                LCDL_MODE_DUPLEX: begin
                    if (b == 2) begin
                        bp_d[b] = `LCDL_LV_LOW; // RULE9
                    end else if (slot == 2'(b)) begin
                        bp_d[b] = pol ? `LCDL_LV_FULL : `LCDL_LV_GND; // RULE8
                    end else begin
                        bp_d[b] = `LCDL_LV_LOW;
                    end
                end
                LCDL_MODE_TRIPLEX: begin
                    if (slot == 2'(b)) begin
                        bp_d[b] = pol ? `LCDL_LV_FULL : `LCDL_LV_GND; // RULE8
                    end else begin
                        bp_d[b] = pol ? `LCDL_LV_LOW : `LCDL_LV_HIGH; // RULE15
                    end
                end
                LCDL_MODE_TEST: begin
                    bp_d[b] = `LCDL_LV_GND;
                end
            endcase
        end
    end

    // Segment levels from the slot's bank bit and the phase
    for (genvar n = 0; n < NUM_SEG; n++) begin : g_seg
        logic bit_on;
        always_comb begin
            bit_on = 1'b0;
            unique case (slot)
                2'd1: bit_on = latch_q[NUM_SEG + n]; // RULE6
                2'd2: bit_on = latch_q[2*NUM_SEG + n];
                2'd0, 2'd3: bit_on = latch_q[n];
            endcase
        end
        always_comb begin
            if (bit_on) begin
                seg_d[2*n +: 2] = pol ? `LCDL_LV_GND : `LCDL_LV_FULL; // RULE2 RULE7
            end else if (mode == LCDL_MODE_TRIPLEX) begin
                seg_d[2*n +: 2] = pol ? `LCDL_LV_HIGH : `LCDL_LV_LOW; // RULE7
            end else begin
                seg_d[2*n +: 2] = pol ? `LCDL_LV_FULL : `LCDL_LV_GND; // RULE7
            end
        end
    end

    // Registered level select codes toward the analog switches
    always_ff @(posedge clk) begin
        if (srst || !drive_on) begin
            segment_drive_outputs <= '0; // RULE13
            backplane_out_first <= `LCDL_LV_GND;
            backplane_out_second <= `LCDL_LV_GND;
            backplane_out_third <= `LCDL_LV_GND;
        end else begin
            segment_drive_outputs <= seg_d; // RULE14
            backplane_out_first <= bp_d[0];
            backplane_out_second <= bp_d[1];
            backplane_out_third <= bp_d[2];
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence s_load_req;
        active_q && frame_clk && !shift_window_enable;
    endsequence
    sequence s_loaded;
        latch_q == $past(shift_reg_data);
    endsequence

    AST_LATCH_LOAD: assert property (s_load_req |=> s_loaded) // RULE4
        else $error("latch did not take shift data on frame clock");
    AST_LATCH_HOLD: assert property (shift_window_enable |=> $stable(latch_q)) // RULE3
        else $error("latch changed during shift window");
    AST_LATCH_FRAME_ONLY: assert property (!frame_clk |=> $stable(latch_q)) // RULE4
        else $error("latch changed outside frame clock");
    AST_POWER_DOWN_GND: assert property (!active_q |=> segment_drive_outputs == '0
        && backplane_out_first == `LCDL_LV_GND && backplane_out_second == `LCDL_LV_GND
        && backplane_out_third == `LCDL_LV_GND) // RULE13
        else $error("outputs not at ground while powered down");
    AST_BP3_DUPLEX: assert property (active_q && mode == LCDL_MODE_DUPLEX
        |=> backplane_out_third == `LCDL_LV_LOW) // RULE9
        else $error("third backplane not at half bias in duplex");
    AST_STATIC_BP: assert property (mode == LCDL_MODE_STATIC
        |=> backplane_out_second == `LCDL_LV_GND && backplane_out_third == `LCDL_LV_GND) // RULE10
        else $error("second or third backplane not grounded in static");
    AST_STATIC_SEG: assert property (active_q && mode == LCDL_MODE_STATIC
        |=> segment_drive_outputs[1:0] == ($past(latch_q[0])
            ? ~backplane_out_first : backplane_out_first)) // RULE2
        else $error("static segment does not follow its latched bit");
    AST_DUPLEX_ONE_BP: assert property (active_q && mode == LCDL_MODE_DUPLEX
        |=> (backplane_out_first == `LCDL_LV_LOW) != (backplane_out_second == `LCDL_LV_LOW)) // RULE8
        else $error("duplex must select exactly one backplane");
    AST_TEST_MODE_OFF: assert property (mode == LCDL_MODE_TEST
        |=> segment_drive_outputs == '0 && backplane_out_first == `LCDL_LV_GND) // RULE11
        else $error("test mode code did not blank the outputs");
endmodule

// ===== pkg/lcdl_cfg.svh
// Constants of the LCD latch and drive sequencer
`ifndef LCDL_CFG_SVH
`define LCDL_CFG_SVH
`define LCDL_FRAME_DIV 2400
`define LCDL_NUM_SEG 32
`define LCDL_NUM_BANK 3
`define LCDL_NUM_BP 3
`define LCDL_LV_GND 2'h0
`define LCDL_LV_LOW 2'h1
`define LCDL_LV_HIGH 2'h2
`define LCDL_LV_FULL 2'h3
`endif

// ===== pkg/lcdl_pkg.sv
// Types of the LCD latch and drive sequencer
package lcdl_pkg;
    typedef enum logic [1:0] {
        LCDL_MODE_TEST = 2'b00,
        LCDL_MODE_STATIC = 2'b01,
        LCDL_MODE_DUPLEX = 2'b10,
        LCDL_MODE_TRIPLEX = 2'b11
    } lcdl_mode_t;
    typedef logic [1:0] lcdl_level_t;
endpackage

// ===== verif/lcdl_glass_model.sv
// Passive three-backplane LCD glass: reports selected backplanes and lit pixels
`timescale 1ns/1ps
`include "lcdl_cfg.svh"
module lcdl_glass_model
    import lcdl_pkg::*;
(
    input wire logic [63:0] segment_drive_outputs,
    input wire logic [1:0] bp_first,
    input wire logic [1:0] bp_second,
    input wire logic [1:0] bp_third,
    output logic [2:0] bp_sel,
    output logic [95:0] lit
);
    // A pixel lights only with the full supply across it
    function automatic logic full_swing(input lcdl_level_t a, input lcdl_level_t b);
        return (a == `LCDL_LV_GND && b == `LCDL_LV_FULL) ||
            (a == `LCDL_LV_FULL && b == `LCDL_LV_GND);
    endfunction
    always_comb begin
        bp_sel[0] = (bp_first == `LCDL_LV_GND) || (bp_first == `LCDL_LV_FULL);
        bp_sel[1] = (bp_second == `LCDL_LV_GND) || (bp_second == `LCDL_LV_FULL);
        bp_sel[2] = (bp_third == `LCDL_LV_GND) || (bp_third == `LCDL_LV_FULL);
        for (int n = 0; n < 32; n++) begin
            lit[n] = full_swing(segment_drive_outputs[2*n+:2], bp_first);
            lit[32+n] = full_swing(segment_drive_outputs[2*n+:2], bp_second);
            lit[64+n] = full_swing(segment_drive_outputs[2*n+:2], bp_third);
        end
    end
endmodule

// ===== verif/lcdl_latch_drive_tb.sv
// Self-checking bench of the latch and drive sequencer against the glass model
`timescale 1ns/1ps
module lcdl_latch_drive_tb;
    import lcdl_pkg::*;
    localparam int FD = 24;
    // Oscillator ticks come every other clock, so one frame spans FC clocks
    localparam int FC = 2 * FD;
    typedef struct {logic [95:0] img; int nbp;} lcdl_tb_note_t;
    logic clk = 1'b0, srst = 1'b1, osc_tick = 1'b1, serial_clock = 1'b0;
    logic shift_window_enable = 1'b0, obs_go = 1'b0;
    logic [1:0] mode = 2'b01;
    logic [95:0] shift_reg_data = 96'h0, data_now, lit;
    logic [63:0] segment_drive_outputs;
    logic [1:0] bp_first, bp_second, bp_third, prev_bp;
    logic [2:0] bp_sel;
    lcdl_tb_note_t notes[$];
    lcdl_tb_note_t nt;
    int cnt[3];
    int n3, n_chg, n_errors = 0, tests_run = 0;
    int unsigned seed;
    always #5 clk = ~clk;
    always @(posedge clk) osc_tick <= ~osc_tick;
    lcdl_latch_drive #(.FRAME_DIV(FD)) u_lcdl_latch_drive (.clk(clk), .srst(srst),
        .osc_tick(osc_tick), .serial_clock(serial_clock),
        .shift_window_enable(shift_window_enable), .drive_mode_sel_low(mode[0]),
        .drive_mode_sel_high(mode[1]), .shift_reg_data(shift_reg_data),
        .segment_drive_outputs(segment_drive_outputs), .backplane_out_first(bp_first),
        .backplane_out_second(bp_second), .backplane_out_third(bp_third));
    lcdl_glass_model u_lcdl_glass_model (.segment_drive_outputs(segment_drive_outputs),
        .bp_first(bp_first), .bp_second(bp_second), .bp_third(bp_third),
        .bp_sel(bp_sel), .lit(lit));
    task automatic check(input string what, input logic [95:0] exp, input logic [95:0] got);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tally_and_finish();
        $display("Checks %0d, errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Note what one full frame must show, then let the monitor watch it
    task automatic run_window(input logic [95:0] img, input int nbp);
        notes.push_back('{img: img, nbp: nbp});
        obs_go <= 1'b1;
        @(posedge clk);
        obs_go <= 1'b0;
        cycles(FC + 2);
    endtask
    initial forever begin
        @(posedge clk);
        if (obs_go === 1'b1) begin
            nt = notes.pop_front();
            cnt = '{0, 0, 0};
            n3 = 0;
            n_chg = 0;
            @(negedge clk);
            prev_bp = bp_first;
            repeat (FC) begin
                @(negedge clk);
                if (nt.nbp == 0) begin
                    check("blank", 96'h0, {26'h0, segment_drive_outputs, bp_first,
                        bp_second, bp_third});
                end else begin
                    for (int k = 0; k < nt.nbp; k++) begin
                        if (bp_sel[k] === 1'b1) begin
                            cnt[k]++;
                            check("lit", 96'(nt.img[32*k+:32]), 96'(lit[32*k+:32]));
                        end
                    end
                    n3 += (bp_first === 2'h3);
                    n_chg += (bp_first !== prev_bp);
                    prev_bp = bp_first;
                    if (nt.nbp == 1) check("bp23", 96'h0, 96'({bp_second, bp_third}));
                    if (nt.nbp == 2) check("bp3", 96'h1, 96'(bp_third));
                end
            end
            if (nt.nbp > 0) begin
                for (int k = 0; k < nt.nbp; k++) begin
                    check("slots", 96'(FC / nt.nbp), 96'(cnt[k]));
                end
                check("polarity", 96'(FC / (2 * nt.nbp)), 96'(n3));
                check("bp_steps", 96'((nt.nbp == 1) ? 2 : 4), 96'(n_chg));
            end
        end
    end
    initial begin
        seed = $urandom(32'h66d4d623);
        cycles(3);
        srst <= 1'b0;
        shift_reg_data <= {$urandom(), $urandom(), $urandom()};
        cycles(FD);
        run_window(96'h0, 0);
        serial_clock <= 1'b1;
        for (int m = 1; m < 4; m++) begin
            mode <= m[1:0];
            data_now = {$urandom(), $urandom(), $urandom()};
            shift_reg_data <= data_now;
            cycles(FC / 2 + 4);
            run_window(data_now, m);
        end
        shift_window_enable <= 1'b1;
        cycles(1);
        shift_reg_data <= {$urandom(), $urandom(), $urandom()};
        cycles(FD);
        run_window(data_now, 3);
        shift_window_enable <= 1'b0;
        data_now = shift_reg_data;
        cycles(FC / 2 + 3);
        run_window(data_now, 3);
        mode <= 2'b00;
        cycles(2);
        run_window(96'h0, 0);
        mode <= 2'b01;
        srst <= 1'b1;
        cycles(3);
        srst <= 1'b0;
        cycles(2);
        // Serial clock stays high through reset: no rising edge, so no wake-up
        run_window(96'h0, 0);
        serial_clock <= 1'b0;
        cycles(1);
        serial_clock <= 1'b1;
        cycles(FC);
        run_window(data_now, 1);
        tally_and_finish();
    end
    initial begin
        cycles(3000);
        n_errors++;
        tally_and_finish();
    end
endmodule
